// File: core/cpe_ctrl.sv
// Clock generator and peripheral enable registers on the CPU I/O space
`default_nettype none
module cpe_ctrl #(
   parameter int STABLE_CYC = cpe_pkg::CPE_STABLE_CYC
) (
   input wire logic mclk, // Clock
   input wire logic rst, // Synchronous reset
   input wire logic ce, // Clock enable, freezes state when low
   input wire logic [5:0] io_addr, // I/O register address
   input wire logic io_wr, // Write strobe
   input wire logic io_rd, // Read strobe
   input wire logic [7:0] io_wdata, // Write data
   output logic [7:0] io_rdata, // Read data, registered
   input wire logic pll_lock, // Lock from analog PLL
   input wire logic sleep_req, // Sleep entry from core
   input wire logic sleep_depth_select, // High selects power-down
   output logic pll_stable, // PLL stable indication
   output cpe_pkg::cpe_ratio_t ratio, // Active multiplier and divisor
   output cpe_pkg::cpe_clkctl_t clkctl, // PLL and oscillator controls
   output cpe_pkg::cpe_periph_t periph, // Peripheral enables
   output logic attach_output_pin, // Attach_output_pin pin
   output logic clocks_stopped // Clocks halted in power-down, except the oscillator when CPE_B_OSCKEEP is set
);
   import cpe_pkg::*;

   // The delay counter needs a positive interval, or stable would never be judged by time
   if (STABLE_CYC < 1) begin : g_bad_stable_cyc
      $error("STABLE_CYC must be at least one");
   end

   logic [7:0] clkgen_q;
   logic [7:0] periph_q;
   logic [31:0] dly_q;
   logic stable_d;
   logic pd_q;

   function automatic logic [2:0] speed_div(input logic [1:0] sel);
      case (sel)
         2'h0: speed_div = CPE_DIV4;
         2'h1: speed_div = CPE_DIV5;
         2'h2: speed_div = CPE_DIV6;
         default: speed_div = CPE_DIV6; // Reserved code kept on the slowest safe rate
      endcase
   endfunction : speed_div

   always_ff @(posedge mclk) begin
      if (rst) begin
         clkgen_q <= CPE_CLKGEN_RST;
      end else if (ce && io_wr && io_addr == CPE_ADDR_CLKGEN) begin
         clkgen_q <= io_wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         periph_q <= CPE_PERIPH_RST;
      end else if (ce && io_wr && io_addr == CPE_ADDR_PERIPH) begin
         periph_q <= io_wdata & CPE_PERIPH_WMASK;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         io_rdata <= 8'h00;
      end else if (ce && io_rd) begin
         if (io_addr == CPE_ADDR_CLKGEN) begin
            io_rdata <= clkgen_q;
         end else if (io_addr == CPE_ADDR_PERIPH) begin
            io_rdata <= periph_q;
         end else begin
            io_rdata <= 8'h00;
         end
      end
   end

   // Oscillator can keep running in power-down with the PLL off; delay counts from the PLL enable
   always_ff @(posedge mclk) begin
      if (rst) begin
         dly_q <= 32'h0000_0000;
      end else if (ce) begin
         if (!clkctl.pll_enable) begin
            dly_q <= 32'h0000_0000;
         end else if (dly_q < 32'(STABLE_CYC)) begin
            dly_q <= dly_q + 32'h0000_0001;
         end
      end
   end

   always_comb begin
      if (clkgen_q[CPE_B_LOCKSRC]) begin
         stable_d = pll_lock && clkctl.pll_enable;
      end else begin
         stable_d = clkctl.pll_enable && dly_q >= 32'(STABLE_CYC);
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         pll_stable <= 1'b0;
      end else if (ce) begin
         pll_stable <= stable_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         pd_q <= 1'b0;
      end else if (ce) begin
         pd_q <= sleep_req && sleep_depth_select;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         clocks_stopped <= 1'b0;
         clkctl <= '0;
      end else if (ce) begin
         clocks_stopped <= sleep_req && sleep_depth_select;
         clkctl.osc_enable <= !(sleep_req && sleep_depth_select)
            || clkgen_q[CPE_B_OSCKEEP];
         clkctl.pll_enable <= !(sleep_req && sleep_depth_select);
         clkctl.pll_range <= clkgen_q[CPE_B_RANGE];
         clkctl.charge_pump_ctl <= !clkgen_q[CPE_B_CPI];
         clkctl.recovery_dpll_fast <= clkgen_q[CPE_B_RECSEL];
      end
   end

   // Ratio is only handed over once stable, so the switch never sees a ramping PLL
   always_ff @(posedge mclk) begin
      if (rst) begin
         ratio <= '{mult: CPE_MUL_LO, div: CPE_DIV4};
      end else if (ce && pll_stable) begin
         ratio.mult <= clkgen_q[CPE_B_MUL] ? CPE_MUL_HI : CPE_MUL_LO;
         ratio.div <= speed_div(clkgen_q[1:0]);
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         periph <= '0;
         attach_output_pin <= 1'b0;
      end else if (ce) begin
         periph.spi_en <= periph_q[CPE_B_SPI];
         periph.serial_port_one_en <= periph_q[CPE_B_SER1];
         periph.serial_port_zero_en <= periph_q[CPE_B_SER0];
         periph.usb_clk_en <= periph_q[CPE_B_USB] && !pd_q;
         periph.ext_memory_en <= periph_q[CPE_B_EXTMEM];
         attach_output_pin <= periph_q[CPE_B_ATTACH];
      end
   end

   // Each output sits one register stage behind the stored bit it reflects
   chk_charge_pump_inv: assert property (@(posedge mclk) disable iff (rst)
      ce |=> clkctl.charge_pump_ctl == !$past(clkgen_q[CPE_B_CPI]))
      else $error("charge pump not inverted");
   chk_attach_pin: assert property (@(posedge mclk) disable iff (rst)
      ce |=> attach_output_pin == $past(periph_q[CPE_B_ATTACH]))
      else $error("attach pin mismatch");
   chk_top_bits_zero: assert property (@(posedge mclk) disable iff (rst)
      periph_q[7:6] == 2'h0)
      else $error("top enable bits set");
   chk_ratio_hold: assert property (@(posedge mclk) disable iff (rst)
      !$past(pll_stable) |-> $stable(ratio))
      else $error("ratio moved unstable");
   chk_mult_sel: assert property (@(posedge mclk) disable iff (rst)
      ce && pll_stable |=> ratio.mult == ($past(clkgen_q[CPE_B_MUL]) ? 5'h10 : 5'h08))
      else $error("multiplier wrong");
   chk_div_sel: assert property (@(posedge mclk) disable iff (rst)
      ce && pll_stable |=> ratio.div == ($past(clkgen_q[1]) ? CPE_DIV6
         : $past(clkgen_q[0]) ? CPE_DIV5 : CPE_DIV4))
      else $error("core divisor wrong");
   chk_spi_en: assert property (@(posedge mclk) disable iff (rst)
      ce |=> periph.spi_en == $past(periph_q[CPE_B_SPI]))
      else $error("spi enable wrong");
   chk_ser_en: assert property (@(posedge mclk) disable iff (rst)
      ce |=> periph.serial_port_one_en == $past(periph_q[CPE_B_SER1])
         && periph.serial_port_zero_en == $past(periph_q[CPE_B_SER0]))
      else $error("serial enable wrong");
   chk_usb_clk: assert property (@(posedge mclk) disable iff (rst)
      ce |=> periph.usb_clk_en == ($past(periph_q[CPE_B_USB]) && !$past(pd_q)))
      else $error("usb clock gate wrong");
   chk_ext_mem: assert property (@(posedge mclk) disable iff (rst)
      ce |=> periph.ext_memory_en == $past(periph_q[CPE_B_EXTMEM]))
      else $error("external memory enable wrong");
   chk_recovery_sel: assert property (@(posedge mclk) disable iff (rst)
      ce |=> clkctl.recovery_dpll_fast == $past(clkgen_q[CPE_B_RECSEL]))
      else $error("recovery select wrong");
   // Stable must never run ahead of the selected source: lock, or the full enabled interval
   chk_lock_follow: assert property (@(posedge mclk) disable iff (rst)
      ce && clkgen_q[CPE_B_LOCKSRC]
         |=> pll_stable == ($past(pll_lock) && $past(clkctl.pll_enable)))
      else $error("stable does not follow lock");
   chk_delay_stable: assert property (@(posedge mclk) disable iff (rst)
      ce && !clkgen_q[CPE_B_LOCKSRC] && dly_q < 32'(STABLE_CYC) |=> !pll_stable)
      else $error("stable before delay ran out");
   chk_osc_keep: assert property (@(posedge mclk) disable iff (rst)
      ce && sleep_req && sleep_depth_select
         |=> clkctl.osc_enable == $past(clkgen_q[CPE_B_OSCKEEP]))
      else $error("oscillator keep wrong");
   chk_clocks_stop: assert property (@(posedge mclk) disable iff (rst)
      ce |=> clocks_stopped == ($past(sleep_req) && $past(sleep_depth_select)))
      else $error("clock stop wrong");
   chk_pll_off_sleep: assert property (@(posedge mclk) disable iff (rst)
      ce && sleep_req && sleep_depth_select |=> !clkctl.pll_enable)
      else $error("pll left on in power-down");
   chk_osc_awake: assert property (@(posedge mclk) disable iff (rst)
      ce && !sleep_req |=> clkctl.osc_enable && clkctl.pll_enable)
      else $error("oscillator off while awake");
   chk_ce_freeze: assert property (@(posedge mclk) disable iff (rst)
      !ce |=> $stable(periph) && $stable(ratio) && $stable(clkctl))
      else $error("outputs moved with clock enable low");
endmodule : cpe_ctrl
`default_nettype wire

// File: pkg/cpe_pkg.sv
// Package for the clock and peripheral enable control block
`default_nettype none
package cpe_pkg;
   localparam logic [5:0] CPE_ADDR_PERIPH = 6'h0b;
   localparam logic [5:0] CPE_ADDR_CLKGEN = 6'h0c;
   localparam logic [7:0] CPE_PERIPH_RST = 8'h00;
   localparam logic [7:0] CPE_CLKGEN_RST = 8'h00;
   localparam logic [7:0] CPE_PERIPH_WMASK = 8'h3f;
   localparam int CPE_B_CPI = 7;
   localparam int CPE_B_LOCKSRC = 6;
   localparam int CPE_B_RECSEL = 5;
   localparam int CPE_B_OSCKEEP = 4;
   localparam int CPE_B_RANGE = 3;
   localparam int CPE_B_MUL = 2;
   localparam int CPE_B_SPI = 5;
   localparam int CPE_B_SER1 = 4;
   localparam int CPE_B_SER0 = 3;
   localparam int CPE_B_ATTACH = 2;
   localparam int CPE_B_USB = 1;
   localparam int CPE_B_EXTMEM = 0;
   localparam logic [4:0] CPE_MUL_LO = 5'h08;
   localparam logic [4:0] CPE_MUL_HI = 5'h10;
   localparam logic [2:0] CPE_DIV4 = 3'h4;
   localparam logic [2:0] CPE_DIV5 = 3'h5;
   localparam logic [2:0] CPE_DIV6 = 3'h6;
   localparam int CPE_CLK_MHZ = 25;
   localparam int CPE_STABLE_US = 1000;
   localparam int CPE_STABLE_CYC = CPE_STABLE_US * CPE_CLK_MHZ;

   typedef struct packed {
      logic [4:0] mult;
      logic [2:0] div;
   } cpe_ratio_t;

   typedef struct packed {
      logic pll_enable;
      logic pll_range;
      logic charge_pump_ctl;
      logic recovery_dpll_fast;
      logic osc_enable;
   } cpe_clkctl_t;

   typedef struct packed {
      logic spi_en;
      logic serial_port_one_en;
      logic serial_port_zero_en;
      logic usb_clk_en;
      logic ext_memory_en;
   } cpe_periph_t;
endpackage : cpe_pkg
`default_nettype wire

// File: verification/clock_and_peripheral_enable_tb.sv
// Self-checking testbench for the clock and peripheral enable block
`default_nettype none
module clock_and_peripheral_enable_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cpe_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic io_wr = 1'b0;
   logic io_rd = 1'b0;
   logic pll_lock = 1'b0;
   logic sleep_req = 1'b0;
   logic sleep_depth_select = 1'b0;
   logic [5:0] io_addr = 6'h00;
   logic [7:0] io_wdata = 8'h00;
   logic [7:0] io_rdata;
   logic [7:0] d;
   logic pll_stable;
   logic attach_output_pin;
   logic clocks_stopped;
   cpe_ratio_t ratio;
   cpe_clkctl_t clkctl;
   cpe_periph_t periph;
   int mismatches = 0;
   int tests_run = 0;
   int cycles = 0;

   always #20 mclk = ~mclk;

   // Short stable delay keeps the run brief; expectations use the same 8
   cpe_ctrl #(.STABLE_CYC(8)) dut_u (.mclk(mclk), .rst(rst), .ce(ce), .io_addr(io_addr),
      .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
      .pll_lock(pll_lock), .sleep_req(sleep_req), .sleep_depth_select(sleep_depth_select),
      .pll_stable(pll_stable), .ratio(ratio), .clkctl(clkctl), .periph(periph),
      .attach_output_pin(attach_output_pin), .clocks_stopped(clocks_stopped));

   task final_report;
      if (mismatches == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         mismatches++;
         final_report();
      end
   end

   task chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   // Lands 1 ns after an edge so drives never race the sampling edge
   task tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick

   task wr(input logic [5:0] a, input logic [7:0] v);
      io_addr = a;
      io_wdata = v;
      io_wr = 1'b1;
      tick(1);
      io_wr = 1'b0;
   endtask : wr

   task rd(input logic [5:0] a, input logic [7:0] exp);
      io_addr = a;
      io_rd = 1'b1;
      tick(1);
      io_rd = 1'b0;
      chk(io_rdata, exp);
   endtask : rd

   initial begin
      tick(8);
      rst = 1'b0;
      chk(ratio, {CPE_MUL_LO, CPE_DIV4});
      rd(CPE_ADDR_PERIPH, CPE_PERIPH_RST);
      rd(CPE_ADDR_CLKGEN, CPE_CLKGEN_RST);
      rd(6'h3f, 8'h00);
      chk(8'(pll_stable), 8'h00);
      tick(10);
      chk(8'(pll_stable), 8'h01);
      for (int i = 0; i < 8; i++) begin
         d = 8'h01 << i;
         wr(CPE_ADDR_PERIPH, d);
         tick(2);
         chk({3'h0, periph}, {3'h0, d[5], d[4], d[3], d[1], d[0]});
         chk(8'(attach_output_pin), {7'h00, d[2]});
         rd(CPE_ADDR_PERIPH, d & 8'h3f);
      end
      for (int m = 0; m < 2; m++) begin
         for (int s = 0; s < 3; s++) begin
            d = {m[0], 1'b0, m[0], m[0], m[0], m[0], s[1:0]};
            wr(CPE_ADDR_CLKGEN, d);
            tick(2);
            chk(ratio, {m ? CPE_MUL_HI : CPE_MUL_LO,
               s == 0 ? CPE_DIV4 : s == 1 ? CPE_DIV5 : CPE_DIV6});
            chk({3'h0, clkctl}, {4'h0, m[0], ~m[0], m[0], 1'b1} | 8'h10);
            rd(CPE_ADDR_CLKGEN, d);
         end
      end
      // Last read left nonzero data, so a stale read register would show here
      rd(6'h3f, 8'h00);
      wr(CPE_ADDR_CLKGEN, 8'h40);
      tick(2);
      chk(8'(pll_stable), 8'h00);
      pll_lock = 1'b1;
      tick(2);
      chk(8'(pll_stable), 8'h01);
      sleep_depth_select = 1'b1;
      sleep_req = 1'b1;
      tick(3);
      chk({7'h00, clocks_stopped}, 8'h01);
      chk({7'h00, clkctl.osc_enable}, 8'h00);
      wr(CPE_ADDR_CLKGEN, 8'h10);
      tick(2);
      chk({7'h00, clkctl.osc_enable}, 8'h01);
      sleep_depth_select = 1'b0;
      tick(3);
      chk({7'h00, clocks_stopped}, 8'h00);
      // Frozen clock enable must drop the write entirely
      ce = 1'b0;
      wr(CPE_ADDR_PERIPH, 8'h3f);
      ce = 1'b1;
      rd(CPE_ADDR_PERIPH, 8'h00);
      final_report();
   end
endmodule : clock_and_peripheral_enable_tb
`default_nettype wire
